// >>> iod_pkg.sv
// Constants and types shared by the command decoder files
package iod_pkg;

	// ********************************************************************
	// Frame layout
	// ********************************************************************
	localparam int unsigned FRAME_LEN   = 9;
	localparam logic [3:0]  IDX_INSTR   = 4'h1;
	localparam logic [3:0]  IDX_TYPE    = 4'h2;
	localparam logic [3:0]  IDX_BANK    = 4'h3;
	localparam logic [3:0]  IDX_VAL_MSB = 4'h4;
	localparam logic [3:0]  IDX_VAL_LSB = 4'h7;
	localparam logic [3:0]  IDX_CSUM    = 4'h8;

	// ********************************************************************
	// Instruction codes, banks, types and ports
	// ********************************************************************
	localparam logic [7:0]  INSTR_RESTORE  = 8'h0c;
	localparam logic [7:0]  INSTR_HOMING   = 8'h0d;
	localparam logic [7:0]  INSTR_SET_OUT  = 8'h0e;
	localparam logic [7:0]  INSTR_READ     = 8'h0f;
	localparam logic [7:0]  BANK_INPUTS    = 8'h00;
	localparam logic [7:0]  BANK_ANALOG    = 8'h01;
	localparam logic [7:0]  BANK_OUTPUTS   = 8'h02;
	localparam logic [7:0]  BANK_USER_VAR  = 8'h02;
	localparam logic [7:0]  MOTOR_ZERO     = 8'h00;
	localparam logic [7:0]  HOME_TYPE_START  = 8'h00;
	localparam logic [7:0]  HOME_TYPE_STOP   = 8'h01;
	localparam logic [7:0]  HOME_TYPE_STATUS = 8'h02;
	localparam logic [7:0]  PORT_ZERO      = 8'h00;
	localparam logic [7:0]  PORT_ALL       = 8'hff;
	localparam logic [31:0] VALUE_FROM_ACC = 32'hffffffff;

	// ********************************************************************
	// Reply status codes
	// ********************************************************************
	localparam logic [7:0]  ST_OK        = 8'h64;
	localparam logic [7:0]  ST_BAD_CSUM  = 8'h01;
	localparam logic [7:0]  ST_BAD_INSTR = 8'h02;
	localparam logic [7:0]  ST_BAD_TYPE  = 8'h03;
	localparam logic [7:0]  ST_BAD_VALUE = 8'h04;

	// ********************************************************************
	// Port counts and widths
	// ********************************************************************
	localparam int unsigned NUM_INPUTS = 3;
	localparam int unsigned ADC_WIDTH  = 12;
	localparam logic [7:0]  NUM_IN_PORTS = 8'h03;

	// ********************************************************************
	// State types
	// ********************************************************************
	typedef enum logic [0:0] {
		DEC_IDLE = 1'b0,
		DEC_WAIT = 1'b1
	} iod_dec_state_type;

	typedef struct packed {
		logic [3:0]  idx;
		logic [7:0]  sum;
		logic [7:0]  instr;
		logic [7:0]  kind;
		logic [7:0]  bank;
		logic [31:0] value;
		logic        csum_ok;
		logic        hold;
	} iod_rx_reg_type;

	typedef struct packed {
		iod_dec_state_type     state;
		logic [NUM_INPUTS-1:0] in_meta;
		logic [NUM_INPUTS-1:0] in_sync;
		logic                  out_zero;
		logic                  home_start;
		logic                  home_stop;
		logic                  restore_req;
		logic [7:0]            restore_index;
		logic                  reply_valid;
		logic [7:0]            reply_status;
		logic [7:0]            reply_instr;
		logic [31:0]           reply_value;
		logic [31:0]           acc;
	} iod_dec_reg_type;

endpackage : iod_pkg

// >>> iod_cmd_if.sv
// Carrier for one checked command from the frame receiver to the decoder
`timescale 1ns/10ps
interface iod_cmd_if;
	logic        valid;
	logic        ready;
	logic [7:0]  instr;
	logic [7:0]  kind;
	logic [7:0]  bank;
	logic [31:0] value;
	logic        csum_ok;

	modport source (output valid, output instr, output kind, output bank, output value, output csum_ok, input ready);
	modport sink   (input valid, input instr, input kind, input bank, input value, input csum_ok, output ready);
endinterface : iod_cmd_if

// >>> iod_frame_rx.sv
// Gathers nine frame bytes into one command and checks the checksum
`timescale 1ns/10ps
module iod_frame_rx (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst,
	input  wire logic  ce,
	// Byte stream
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	// Command out
	iod_cmd_if.source       cmd
);
	import iod_pkg::*;

	iod_rx_reg_type r;
	iod_rx_reg_type next_r;

	always_comb begin
		next_r = r;
		if (r.hold) begin
			// Bytes that arrive while a command waits are dropped
			if (cmd.ready) begin
				next_r.hold = 1'b0;
			end
		end else if (byte_valid) begin
			if (r.idx == IDX_CSUM) begin
				next_r.csum_ok = (r.sum == byte_data);
				next_r.hold    = 1'b1;
				next_r.idx     = 4'h0;
				next_r.sum     = 8'h00;
			end else begin
				next_r.sum = 8'(r.sum + byte_data);
				next_r.idx = 4'(r.idx + 4'h1);
				if (r.idx == IDX_INSTR) begin
					next_r.instr = byte_data;
				end
				if (r.idx == IDX_TYPE) begin
					next_r.kind = byte_data;
				end
				if (r.idx == IDX_BANK) begin
					next_r.bank = byte_data;
				end
				if (r.idx >= IDX_VAL_MSB && r.idx <= IDX_VAL_LSB) begin
					next_r.value = {r.value[23:0], byte_data};
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign cmd.valid   = r.hold;
	assign cmd.instr   = r.instr;
	assign cmd.kind    = r.kind;
	assign cmd.bank    = r.bank;
	assign cmd.value   = r.value;
	assign cmd.csum_ok = r.csum_ok;

	a_csum_check: assert property (@(posedge clock) disable iff (rst)
		(ce && byte_valid && !r.hold && r.idx == IDX_CSUM) |=> (r.hold && r.csum_ok == ($past(r.sum) == $past(byte_data))))
		else $error("checksum flag does not match byte sum");

endmodule : iod_frame_rx

// >>> iod_decoder.sv
// Decoder for restore, homing, set-output and read-port commands
`timescale 1ns/10ps

module iod_decoder (
	// Clock and reset
	input  wire logic                                       CLOCK,
	input  wire logic                                       RST,
	input  wire logic                                       CE,
	// Command byte stream
	input  wire logic                                       RX_VALID,
	input  wire logic [7:0]                                 RX_DATA,
	input  wire logic                                       STANDALONE,
	// Pins and converters
	input  wire logic [iod_pkg::NUM_INPUTS-1:0]             GENERAL_INPUTS,
	input  wire logic [iod_pkg::NUM_INPUTS-1:0][iod_pkg::ADC_WIDTH-1:0] ADC_RESULT,
	output logic                                            GENERAL_OUTPUT_ZERO,
	// Homing engine
	input  wire logic                                       HOME_BUSY,
	output logic                                            HOME_START,
	output logic                                            HOME_STOP,
	// Non-volatile memory
	input  wire logic                                       RESTORE_DONE,
	output logic                                            RESTORE_REQ,
	output logic [7:0]                                      RESTORE_INDEX,
	// Reply
	output logic                                            REPLY_VALID,
	output logic [7:0]                                      REPLY_STATUS,
	output logic [7:0]                                      REPLY_INSTR,
	output logic [31:0]                                     REPLY_VALUE,
	output logic [31:0]                                     ACCUMULATOR
);
	import iod_pkg::*;

	// ********************************************************************
	// Frame receiver
	// ********************************************************************
	iod_cmd_if cmd ();

	iod_frame_rx u_rx (
		.clock      (CLOCK),
		.rst        (RST),
		.ce         (CE),
		.byte_valid (RX_VALID),
		.byte_data  (RX_DATA),
		.cmd        (cmd.source)
	);

	// ********************************************************************
	// Decode and execute
	// ********************************************************************
	iod_dec_reg_type r;
	iod_dec_reg_type next_r;
	logic [31:0]     read_val;
	logic [31:0]     out_vec;
	logic            read_ok;
	logic            take;

	// One command at a time; a restore holds off the next one
	assign cmd.ready = (r.state == DEC_IDLE);
	assign take      = CE && cmd.valid && cmd.ready;

	always_comb begin
		next_r             = r;
		read_val           = 32'h00000000;
		out_vec            = 32'h00000000;
		read_ok            = 1'b0;
		next_r.in_meta     = GENERAL_INPUTS;
		next_r.in_sync     = r.in_meta;
		next_r.home_start  = 1'b0;
		next_r.home_stop   = 1'b0;
		next_r.restore_req = 1'b0;
		next_r.reply_valid = 1'b0;
		unique case (r.state)
			DEC_IDLE: begin
				if (cmd.valid) begin
					next_r.reply_valid  = 1'b1;
					next_r.reply_instr  = cmd.instr;
					next_r.reply_status = ST_OK;
					next_r.reply_value  = 32'h00000000;
					if (!cmd.csum_ok) begin
						next_r.reply_status = ST_BAD_CSUM;
					end else begin
						unique case (cmd.instr)
							INSTR_RESTORE: begin
								if (cmd.bank != BANK_USER_VAR) begin
									next_r.reply_status = ST_BAD_VALUE;
								end else begin
									// Reply waits for the memory to finish
									next_r.reply_valid   = 1'b0;
									next_r.restore_req   = 1'b1;
									next_r.restore_index = cmd.kind;
									next_r.state         = DEC_WAIT;
								end
							end
							INSTR_HOMING: begin
								if (cmd.bank != MOTOR_ZERO) begin
									next_r.reply_status = ST_BAD_VALUE;
								end else if (cmd.kind == HOME_TYPE_START) begin
									next_r.home_start = 1'b1;
								end else if (cmd.kind == HOME_TYPE_STOP) begin
									next_r.home_stop = 1'b1;
								end else if (cmd.kind == HOME_TYPE_STATUS) begin
									next_r.reply_value = {31'h00000000, HOME_BUSY};
								end else begin
									next_r.reply_status = ST_BAD_TYPE;
								end
							end
							INSTR_SET_OUT: begin
								out_vec = (cmd.value == VALUE_FROM_ACC) ? r.acc : cmd.value;
								if (cmd.bank != BANK_OUTPUTS) begin
									next_r.reply_status = ST_BAD_VALUE;
								end else if (cmd.kind == PORT_ZERO) begin
									if (cmd.value[31:1] != 31'h00000000) begin
										next_r.reply_status = ST_BAD_VALUE;
									end else begin
										next_r.out_zero = cmd.value[0];
									end
								end else if (cmd.kind == PORT_ALL) begin
									next_r.out_zero = out_vec[0];
								end else begin
									next_r.reply_status = ST_BAD_TYPE;
								end
							end
							INSTR_READ: begin
								if (cmd.bank == BANK_INPUTS && cmd.kind == PORT_ALL) begin
									read_val   = {29'h00000000, r.in_sync};
									next_r.acc = read_val;
									read_ok    = 1'b1;
								end else if (cmd.bank == BANK_INPUTS && cmd.kind < NUM_IN_PORTS) begin
									read_val = {31'h00000000, r.in_sync[cmd.kind[1:0]]};
									read_ok  = 1'b1;
								end else if (cmd.bank == BANK_ANALOG && cmd.kind < NUM_IN_PORTS) begin
									read_val = {20'h00000, ADC_RESULT[cmd.kind[1:0]]};
									read_ok  = 1'b1;
								end else if (cmd.bank == BANK_OUTPUTS && cmd.kind == PORT_ZERO) begin
									read_val = {31'h00000000, r.out_zero};
									read_ok  = 1'b1;
								end
								if (read_ok) begin
									next_r.reply_value = read_val;
									if (STANDALONE) begin
										next_r.acc = read_val;
									end
								end else begin
									next_r.reply_status = ST_BAD_TYPE;
								end
							end
							default: begin
								next_r.reply_status = ST_BAD_INSTR;
							end
						endcase
					end
				end
			end
			DEC_WAIT: begin
				if (RESTORE_DONE) begin
					next_r.reply_valid  = 1'b1;
					next_r.reply_status = ST_OK;
					next_r.reply_value  = 32'h00000000;
					next_r.state        = DEC_IDLE;
				end
			end
		endcase
	end

	// Frozen state while the clock enable is low keeps the host's view steady
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			r <= '0;
		end else if (CE) begin
			r <= next_r;
		end
	end

	assign GENERAL_OUTPUT_ZERO = r.out_zero;
	assign HOME_START          = r.home_start;
	assign HOME_STOP           = r.home_stop;
	assign RESTORE_REQ         = r.restore_req;
	assign RESTORE_INDEX       = r.restore_index;
	assign REPLY_VALID         = r.reply_valid;
	assign REPLY_STATUS        = r.reply_status;
	assign REPLY_INSTR         = r.reply_instr;
	assign REPLY_VALUE         = r.reply_value;
	assign ACCUMULATOR         = r.acc;

	// ********************************************************************
	// Checks
	// ********************************************************************
	a_restore_request: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_RESTORE && cmd.bank == BANK_USER_VAR)
		|=> (RESTORE_REQ && !REPLY_VALID && RESTORE_INDEX == $past(cmd.kind)))
		else $error("restore not requested for the selected variable");

	a_restore_reply: assert property (@(posedge CLOCK) disable iff (RST)
		(CE && r.state == DEC_WAIT && RESTORE_DONE) |=> (REPLY_VALID && REPLY_STATUS == ST_OK && cmd.ready))
		else $error("restore completion gave no OK reply");

	a_homing_start: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_HOMING && cmd.bank == MOTOR_ZERO && cmd.kind == HOME_TYPE_START)
		|=> (HOME_START && !HOME_STOP && REPLY_VALID && REPLY_STATUS == ST_OK) ##1 (!HOME_START || !$past(CE)))
		else $error("homing start not a single pulse with OK reply");

	a_homing_query: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_HOMING && cmd.bank == MOTOR_ZERO && cmd.kind == HOME_TYPE_STATUS)
		|=> (REPLY_VALID && ((REPLY_VALUE != 32'h00000000) == $past(HOME_BUSY))))
		else $error("homing query value does not follow busy");

	a_output_set: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_SET_OUT && cmd.bank == BANK_OUTPUTS && cmd.kind == PORT_ZERO
		&& cmd.value[31:1] == 31'h00000000) |=> (GENERAL_OUTPUT_ZERO == $past(cmd.value[0])))
		else $error("output not set to commanded level");

	a_output_from_acc: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_SET_OUT && cmd.bank == BANK_OUTPUTS && cmd.kind == PORT_ALL
		&& cmd.value == VALUE_FROM_ACC) |=> (GENERAL_OUTPUT_ZERO == $past(r.acc[0])))
		else $error("all-outputs set ignored the accumulator");

	a_read_direct: assert property (@(posedge CLOCK) disable iff (RST)
		(take && !STANDALONE && cmd.csum_ok && cmd.instr == INSTR_READ && !(cmd.bank == BANK_INPUTS && cmd.kind == PORT_ALL))
		|=> $stable(ACCUMULATOR))
		else $error("direct read disturbed the accumulator");

	a_read_standalone: assert property (@(posedge CLOCK) disable iff (RST)
		(take && STANDALONE && cmd.csum_ok && cmd.instr == INSTR_READ) |=> (REPLY_STATUS != ST_OK || ACCUMULATOR == REPLY_VALUE))
		else $error("standalone read not copied to accumulator");

	a_read_output: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_READ && cmd.bank == BANK_OUTPUTS && cmd.kind == PORT_ZERO)
		|=> (REPLY_VALUE == {31'h00000000, GENERAL_OUTPUT_ZERO}))
		else $error("output read does not show driven level");

	a_analog_range: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_READ && cmd.bank == BANK_ANALOG) |=> (REPLY_VALUE < 32'h00001000))
		else $error("analog read out of range");

	a_inputs_vector: assert property (@(posedge CLOCK) disable iff (RST)
		(take && cmd.csum_ok && cmd.instr == INSTR_READ && cmd.bank == BANK_INPUTS && cmd.kind == PORT_ALL)
		|=> (ACCUMULATOR == {29'h00000000, $past(r.in_sync)}))
		else $error("input vector not loaded into accumulator");

	a_checksum_reply: assert property (@(posedge CLOCK) disable iff (RST)
		(take && !cmd.csum_ok) |=> (REPLY_VALID && REPLY_STATUS == ST_BAD_CSUM && !RESTORE_REQ && !HOME_START))
		else $error("bad checksum frame was executed");

endmodule : iod_decoder

// >>> iod_host_model.sv
// Host and far-side model: frames commands, plays homing engine and memory
`timescale 1ns/10ps
module iod_host_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Requests from the decoder
	input  wire logic       home_start,
	input  wire logic       home_stop,
	input  wire logic       restore_req,
	// Byte stream and far-side status
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            home_busy,
	output logic            restore_done
);
	logic [2:0] wait_cnt;

	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h5a;
	end

	// ********************************************************************
	// Homing engine and slow memory
	// ********************************************************************
	// Memory answers late on purpose so the decoder's wait state is exercised
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			home_busy    <= 1'b0;
			wait_cnt     <= 3'h0;
			restore_done <= 1'b0;
		end else begin
			if (home_start) begin
				home_busy <= 1'b1;
			end else if (home_stop) begin
				home_busy <= 1'b0;
			end
			if (restore_req) begin
				wait_cnt <= 3'h5;
			end else if (wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
			end
			restore_done <= (wait_cnt == 3'h1);
		end
	end

	// ********************************************************************
	// Frame sender
	// ********************************************************************
	task automatic send_frame(input logic [7:0] instr, input logic [7:0] kind, input logic [7:0] bank,
		input logic [31:0] value, input logic bad);
		logic [7:0] b [9];
		b[0] = 8'h01;
		b[1] = instr;
		b[2] = kind;
		b[3] = bank;
		b[4] = value[31:24];
		b[5] = value[23:16];
		b[6] = value[15:8];
		b[7] = value[7:0];
		b[8] = 8'h00;
		for (int i = 0; i < 8; i++) begin
			b[8] = b[8] + b[i];
		end
		if (bad) begin
			b[8] = b[8] ^ 8'h01;
		end
		for (int i = 0; i < 9; i++) begin
			@(posedge clock);
			rx_valid <= 1'b1;
			rx_data  <= b[i];
		end
		// Released line shows the inverse so a stale byte is never mistaken for data
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_data  <= ~b[8];
	endtask : send_frame
endmodule : iod_host_model

// >>> io_and_homing_command_decoder_tb.sv
// Self-checking testbench for the command decoder
`timescale 1ns/10ps
module io_and_homing_command_decoder_tb;
	import iod_pkg::*;

	logic                                   clock;
	logic                                   rst;
	logic                                   ce;
	logic                                   rx_valid;
	logic [7:0]                             rx_data;
	logic                                   standalone;
	logic [NUM_INPUTS-1:0]                  gen_in;
	logic [NUM_INPUTS-1:0][ADC_WIDTH-1:0]   adc_result;
	logic                                   out_zero;
	logic                                   home_busy;
	logic                                   home_start;
	logic                                   home_stop;
	logic                                   restore_done;
	logic                                   restore_req;
	logic [7:0]                             restore_index;
	logic                                   reply_valid;
	logic [7:0]                             reply_status;
	logic [7:0]                             reply_instr;
	logic [31:0]                            reply_value;
	logic [31:0]                            acc;
	int                                     mismatches;
	int                                     n_tests;
	int                                     n_start;
	int                                     n_stop;
	int                                     n_restore;

	iod_decoder DUT (.CLOCK(clock), .RST(rst), .CE(ce), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.STANDALONE(standalone), .GENERAL_INPUTS(gen_in), .ADC_RESULT(adc_result),
		.GENERAL_OUTPUT_ZERO(out_zero), .HOME_BUSY(home_busy), .HOME_START(home_start),
		.HOME_STOP(home_stop), .RESTORE_DONE(restore_done), .RESTORE_REQ(restore_req),
		.RESTORE_INDEX(restore_index), .REPLY_VALID(reply_valid), .REPLY_STATUS(reply_status),
		.REPLY_INSTR(reply_instr), .REPLY_VALUE(reply_value), .ACCUMULATOR(acc));

	iod_host_model host (.clock(clock), .rst(rst), .home_start(home_start), .home_stop(home_stop),
		.restore_req(restore_req), .rx_valid(rx_valid), .rx_data(rx_data), .home_busy(home_busy),
		.restore_done(restore_done));

	always #4 clock = ~clock;

	// Pulse counters on the pulse's own edge: the count is current as soon as the reply is
	// Requests are a whole frame apart, so two pulses never merge into one edge
	always @(posedge home_start) n_start++;
	always @(posedge home_stop) n_stop++;
	always @(posedge restore_req) n_restore++;

	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic run_cmd(input logic [7:0] instr, input logic [7:0] kind, input logic [7:0] bank,
		input logic [31:0] value, input logic bad);
		host.send_frame(instr, kind, bank, value, bad);
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			#1;
			if (reply_valid === 1'b1) return;
		end
		mismatches++;
		$display("Reply wait ran out at %0t", $time);
		complete_run();
	endtask : run_cmd

	task automatic check_reply(input logic [7:0] st, input logic [31:0] val);
		check_val({24'h0, reply_status}, {24'h0, st});
		check_val(reply_value, val);
	endtask : check_reply

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic t_set_out();
		run_cmd(INSTR_SET_OUT, 8'h00, 8'h02, 32'h1, 1'b0);
		check_reply(ST_OK, 32'h0);
		check_val({31'h0, out_zero}, 32'h1);
		check_val({24'h0, reply_instr}, 32'he);
		run_cmd(INSTR_READ, 8'h00, 8'h02, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h1);
		run_cmd(INSTR_SET_OUT, 8'h00, 8'h02, 32'h2, 1'b0);
		check_reply(ST_BAD_VALUE, 32'h0);
		check_val({31'h0, out_zero}, 32'h1);
		run_cmd(INSTR_SET_OUT, 8'h00, 8'h02, 32'h0, 1'b0);
		check_val({31'h0, out_zero}, 32'h0);
		run_cmd(INSTR_READ, 8'h00, 8'h02, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		$display("Test set_out done");
	endtask : t_set_out

	task automatic t_set_all();
		run_cmd(INSTR_SET_OUT, PORT_ALL, 8'h02, 32'h1, 1'b0);
		check_val({31'h0, out_zero}, 32'h1);
		run_cmd(INSTR_SET_OUT, PORT_ALL, 8'h02, 32'h2, 1'b0);
		check_val({31'h0, out_zero}, 32'h0);
		@(posedge clock);
		gen_in <= 3'b101;
		run_cmd(INSTR_READ, PORT_ALL, 8'h00, 32'h0, 1'b0);
		check_val(acc, 32'h5);
		run_cmd(INSTR_SET_OUT, PORT_ALL, 8'h02, VALUE_FROM_ACC, 1'b0);
		check_val({31'h0, out_zero}, 32'h1);
		@(posedge clock);
		gen_in <= 3'b100;
		run_cmd(INSTR_READ, PORT_ALL, 8'h00, 32'h0, 1'b0);
		check_val(acc, 32'h4);
		run_cmd(INSTR_SET_OUT, PORT_ALL, 8'h02, VALUE_FROM_ACC, 1'b0);
		check_val({31'h0, out_zero}, 32'h0);
		$display("Test set_all done");
	endtask : t_set_all

	task automatic t_inputs();
		@(posedge clock);
		gen_in <= 3'b101;
		run_cmd(INSTR_READ, PORT_ALL, 8'h00, 32'h0, 1'b0);
		run_cmd(INSTR_READ, 8'h01, 8'h00, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		check_val(acc, 32'h5);
		run_cmd(INSTR_READ, 8'h02, 8'h01, 32'h0, 1'b0);
		check_reply(ST_OK, 32'hfff);
		check_val(acc, 32'h5);
		@(posedge clock);
		standalone <= 1'b1;
		run_cmd(INSTR_READ, 8'h02, 8'h00, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h1);
		check_val(acc, 32'h1);
		run_cmd(INSTR_READ, 8'h00, 8'h01, 32'h0, 1'b0);
		check_val(acc, 32'h12e);
		@(posedge clock);
		standalone <= 1'b0;
		$display("Test inputs done");
	endtask : t_inputs

	task automatic t_homing();
		int s0;
		s0 = n_start;
		run_cmd(INSTR_HOMING, HOME_TYPE_START, 8'h01, 32'h0, 1'b0);
		check_reply(ST_BAD_VALUE, 32'h0);
		check_val(n_start, s0);
		run_cmd(INSTR_HOMING, HOME_TYPE_START, MOTOR_ZERO, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		check_val(n_start, s0 + 1);
		run_cmd(INSTR_HOMING, HOME_TYPE_STATUS, MOTOR_ZERO, 32'h0, 1'b0);
		check_val({31'h0, reply_value != 32'h0}, 32'h1);
		run_cmd(INSTR_HOMING, HOME_TYPE_STOP, MOTOR_ZERO, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		check_val(n_stop, 32'h1);
		run_cmd(INSTR_HOMING, HOME_TYPE_STATUS, MOTOR_ZERO, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		$display("Test homing done");
	endtask : t_homing

	task automatic t_restore_and_csum();
		run_cmd(INSTR_RESTORE, 8'h2a, BANK_USER_VAR, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		check_val(n_restore, 32'h1);
		check_val({24'h0, restore_index}, 32'h2a);
		run_cmd(INSTR_SET_OUT, 8'h00, 8'h02, 32'h1, 1'b1);
		check_reply(ST_BAD_CSUM, 32'h0);
		check_val({31'h0, out_zero}, 32'h0);
		$display("Test restore_and_csum done");
	endtask : t_restore_and_csum

	task automatic t_errors();
		int r0;
		r0 = n_restore;
		run_cmd(8'h13, 8'h00, 8'h00, 32'h0, 1'b0);
		check_reply(ST_BAD_INSTR, 32'h0);
		run_cmd(INSTR_HOMING, 8'h03, MOTOR_ZERO, 32'h0, 1'b0);
		check_reply(ST_BAD_TYPE, 32'h0);
		run_cmd(INSTR_READ, 8'h05, BANK_INPUTS, 32'h0, 1'b0);
		check_reply(ST_BAD_TYPE, 32'h0);
		run_cmd(INSTR_SET_OUT, 8'h01, BANK_OUTPUTS, 32'h1, 1'b0);
		check_reply(ST_BAD_TYPE, 32'h0);
		run_cmd(INSTR_RESTORE, 8'h2a, 8'h00, 32'h0, 1'b0);
		check_reply(ST_BAD_VALUE, 32'h0);
		check_val(n_restore, r0);
		$display("Test errors done");
	endtask : t_errors

	task automatic t_freeze();
		// A frame sent while the clock enable is low must leave no trace
		@(posedge clock);
		ce <= 1'b0;
		host.send_frame(INSTR_SET_OUT, PORT_ZERO, BANK_OUTPUTS, 32'h1, 1'b0);
		repeat (3) @(posedge clock);
		#1;
		check_val({31'h0, reply_valid}, 32'h0);
		check_val({31'h0, out_zero}, 32'h0);
		@(posedge clock);
		ce <= 1'b1;
		run_cmd(INSTR_READ, PORT_ZERO, BANK_OUTPUTS, 32'h0, 1'b0);
		check_reply(ST_OK, 32'h0);
		$display("Test freeze done");
	endtask : t_freeze

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		standalone = 1'b0;
		gen_in = 3'b000;
		adc_result = {12'hfff, 12'h0aa, 12'h12e};
		mismatches = 0;
		n_tests = 0;
		n_start = 0;
		n_stop = 0;
		n_restore = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_set_out();
		t_set_all();
		t_inputs();
		t_homing();
		t_errors();
		t_restore_and_csum();
		t_freeze();
		complete_run();
	end
endmodule : io_and_homing_command_decoder_tb
